/* File: core/ansnr_mon_if.sv */
// Signals between the register bank and the parallel-detect monitor
`timescale 1ns/1ps
interface ansnr_mon_if;
    logic autonegActive;
    logic linkValidDet;
    logic linkFail;
    logic link10Good;
    logic link100Good;
    logic faultPulse;

    // Monitor side
    modport mon (
        input autonegActive,
        input linkValidDet,
        input linkFail,
        input link10Good,
        input link100Good,
        output faultPulse
    );

    // Register bank side
    modport owner (
        output autonegActive,
        output linkValidDet,
        output linkFail,
        output link10Good,
        output link100Good,
        input faultPulse
    );
endinterface

/* File: core/ansnr_pdf_mon.sv */
// Parallel-detect fault monitor with timed link failure window
`timescale 1ns/1ps
module ansnr_pdf_mon #(
    parameter int MIN_CYC = ansnr_pkg::PDF_MIN_CYC,
    parameter int MAX_CYC = ansnr_pkg::PDF_MAX_CYC
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Link events
    ansnr_mon_if.mon m
);
    localparam logic [ansnr_pkg::PDF_CNT_W-1:0] MIN_C = ansnr_pkg::PDF_CNT_W'(MIN_CYC);
    localparam logic [ansnr_pkg::PDF_CNT_W-1:0] MAX_C = ansnr_pkg::PDF_CNT_W'(MAX_CYC);

    logic armed_r;
    logic [ansnr_pkg::PDF_CNT_W-1:0] cnt_r;
    logic fault_r;
    logic failInWin;
    logic bothGood;

    // Failure counts only inside the window after a valid link
    assign failInWin = armed_r && m.linkFail && (cnt_r >= MIN_C) && (cnt_r <= MAX_C);
    assign bothGood = m.autonegActive && m.link10Good && m.link100Good;

    // Window timer, armed by a detected valid link
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            armed_r <= 1'b0;
            cnt_r <= '0;
        end else if (m.autonegActive && m.linkValidDet) begin
            armed_r <= 1'b1;
            cnt_r <= '0;
        end else if (!m.autonegActive || m.linkFail || (cnt_r == MAX_C)) begin
            armed_r <= 1'b0;
            cnt_r <= '0;
        end else if (armed_r) begin
            cnt_r <= cnt_r + 1'b1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            fault_r <= 1'b0;
        end else begin
            fault_r <= failInWin || bothGood;
        end
    end

    assign m.faultPulse = fault_r;
endmodule

/* File: core/ansnr_pin_sync.sv */
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module ansnr_pin_sync (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Pins and filtered levels
    input wire logic [ansnr_pkg::RX_PAIR_W-1:0] din,
    output logic [ansnr_pkg::RX_PAIR_W-1:0] dout
);
    genvar i;
    generate
        for (i = 0; i < ansnr_pkg::RX_PAIR_W; i++) begin : g_bit
            logic s1_r;
            logic s2_r;
            logic s3_r;
            logic out_r;
            // Chain; stage one feeds stage two only
            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    s1_r <= 1'b0;
                    s2_r <= 1'b0;
                    s3_r <= 1'b0;
                    out_r <= 1'b0;
                end else begin
                    s1_r <= din[i];
                    s2_r <= s1_r;
                    s3_r <= s2_r;
                    if (s2_r == s3_r) begin
                        out_r <= s3_r;
                    end
                end
            end
            assign dout[i] = out_r;
        end
    endgenerate
endmodule

/* File: core/ansnr_pkg.sv */
// Constants for the autonegotiation status and next-page register bank
package ansnr_pkg;
    // Register port geometry
    localparam int ADDR_W = 5;
    localparam int DATA_W = 16;

    // Register offsets
    localparam logic [4:0] ADDR_EXPANSION = 5'h06;
    localparam logic [4:0] ADDR_NEXT_PAGE = 5'h07;
    localparam logic [4:0] ADDR_IDENT = 5'h10;
    localparam logic [4:0] ADDR_CONTROL = 5'h11;
    localparam logic [4:0] ADDR_INT_STATUS = 5'h18;
    localparam logic [4:0] ADDR_INT_CLEAR = 5'h19;
    localparam logic [4:0] ADDR_INT_ENABLE = 5'h1A;

    // Expansion register fields
    localparam int EXP_PDF_BIT = 4;
    localparam int EXP_LPNP_BIT = 3;
    localparam int EXP_NPABLE_BIT = 2;
    localparam int EXP_PAGE_RECEIVED_FLAG_BIT = 1;
    localparam int EXP_LPAN_BIT = 0;

    // Next-page register fields and reset value
    localparam int NP_MORE_BIT = 15;
    localparam int NP_ACK_BIT = 14;
    localparam int NP_MSG_BIT = 13;
    localparam int NP_SECOND_HANDSHAKE_CONFIRM_BIT = 12;
    localparam int NP_TOGGLE_BIT = 11;
    localparam int NP_CODE_MSB = 10;
    localparam logic [15:0] NP_RESET = 16'h2001;
    localparam logic [15:0] NP_SW_MASK = 16'hA7FF;

    // Control register fields and reset value
    localparam int CTL_FORCE_BIT = 15;
    localparam int CTL_SWAP_BIT = 14;
    localparam int CTL_MANUAL_BIT = 13;
    localparam logic [15:0] CTL_RESET = 16'h0000;
    localparam logic [15:0] CTL_SW_MASK = 16'hE000;

    // Identifier value; arbitrary neutral code
    localparam logic [15:0] IDENT_DEFAULT = 16'h5A5A;

    // Interrupt status layout
    localparam int INT_W = 3;
    localparam int INT_PAGE_BIT = 0;
    localparam int INT_PDF_BIT = 1;
    localparam int INT_LPAN_BIT = 2;
    localparam logic [2:0] INT_RESET = 3'h0;

    // Receive pair width
    localparam int RX_PAIR_W = 2;

    // Parallel-detect fault window
    localparam longint CLK_FREQ_HZ = 125000000;
    localparam longint PDF_WIN_MIN_MS = 500;
    localparam longint PDF_WIN_MAX_MS = 1000;
    localparam int PDF_MIN_CYC = int'((PDF_WIN_MIN_MS * CLK_FREQ_HZ + 999) / 1000);
    localparam int PDF_MAX_CYC = int'((PDF_WIN_MAX_MS * CLK_FREQ_HZ) / 1000);
    localparam int PDF_CNT_W = 27;
endpackage

/* File: core/ansnr_regs.sv */
// Autonegotiation expansion, next-page, identifier and control registers
//
// The strobed register port was left to the implementer.
`timescale 1ns/1ps
module ansnr_regs #(
    parameter int PDF_MIN_CYC = ansnr_pkg::PDF_MIN_CYC,
    parameter int PDF_MAX_CYC = ansnr_pkg::PDF_MAX_CYC,
    parameter logic [15:0] IDENT_VALUE = ansnr_pkg::IDENT_DEFAULT
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Management register port
    input wire logic [ansnr_pkg::ADDR_W-1:0] regAddr,
    input wire logic [ansnr_pkg::DATA_W-1:0] regWrData,
    input wire logic regWrEn,
    input wire logic regRdEn,
    output logic [ansnr_pkg::DATA_W-1:0] regRdData,
    // Negotiation engine status
    input wire logic autonegActive,
    input wire logic linkValidDet,
    input wire logic linkFail,
    input wire logic link10Good,
    input wire logic link100Good,
    input wire logic pageStored,
    input wire logic codeWordSeen,
    input wire logic partnerNpAble,
    input wire logic renegotiate,
    input wire logic [2:0] npHandshakeBits,
    // Next-page word to the negotiation engine
    output logic [ansnr_pkg::DATA_W-1:0] npTxWord,
    output logic npMoreFollows,
    // Link integrity
    input wire logic linkPulseStatus,
    output logic linkStatus,
    output logic forceLinkGood,
    // Receive pair polarity
    input wire logic rxPairPos,
    input wire logic rxPairNeg,
    input wire logic autoPolInverted,
    output logic rxPolPos,
    output logic rxPolNeg,
    output logic polarityInverted,
    // Interrupt
    output logic irq
);
    // Carrier to the fault monitor
    ansnr_mon_if monBus ();

    // Read path
    logic [ansnr_pkg::DATA_W-1:0] rdData_r;
    logic [ansnr_pkg::DATA_W-1:0] rdData_nxt;

    // Expansion flags
    logic parallel_detect_fault_r;
    logic page_received_flag_r;
    logic partner_next_page_capable_r;
    logic partner_autoneg_capable_r;

    // Software-written registers
    logic [ansnr_pkg::DATA_W-1:0] nextPage_r;
    logic [ansnr_pkg::DATA_W-1:0] control_r;

    // Interrupt state
    logic [ansnr_pkg::INT_W-1:0] intStatus_r;
    logic [ansnr_pkg::INT_W-1:0] intEnable_r;
    logic [ansnr_pkg::INT_W-1:0] intEvents;
    logic irq_r;

    // Link and polarity state
    logic linkStatus_r;
    logic rxPolPos_r;
    logic rxPolNeg_r;
    logic invert_r;
    logic [ansnr_pkg::RX_PAIR_W-1:0] rxPairSync;

    // Strobe decode and read views
    logic expRead;
    logic wrNextPage;
    logic wrControl;
    logic wrIntClear;
    logic wrIntEnable;
    logic invertNow;
    logic [ansnr_pkg::DATA_W-1:0] expView;
    logic [ansnr_pkg::DATA_W-1:0] npView;

    // Address decode of strobes
    assign expRead = regRdEn && (regAddr == ansnr_pkg::ADDR_EXPANSION);
    assign wrNextPage = regWrEn && (regAddr == ansnr_pkg::ADDR_NEXT_PAGE);
    assign wrControl = regWrEn && (regAddr == ansnr_pkg::ADDR_CONTROL);
    assign wrIntClear = regWrEn && (regAddr == ansnr_pkg::ADDR_INT_CLEAR);
    assign wrIntEnable = regWrEn && (regAddr == ansnr_pkg::ADDR_INT_ENABLE);

    // Monitor hookup
    assign monBus.autonegActive = autonegActive;
    assign monBus.linkValidDet = linkValidDet;
    assign monBus.linkFail = linkFail;
    assign monBus.link10Good = link10Good;
    assign monBus.link100Good = link100Good;

    // Parallel-detect fault monitor
    ansnr_pdf_mon #(
        .MIN_CYC(PDF_MIN_CYC),
        .MAX_CYC(PDF_MAX_CYC)
    ) uPdfMon (
        .clk(clk),
        .rst(rst),
        .m(monBus.mon)
    );

    // Receive pins through the three-stage filter
    ansnr_pin_sync uRxSync (
        .clk(clk),
        .rst(rst),
        .din({rxPairNeg, rxPairPos}),
        .dout(rxPairSync)
    );

    // fault latch, set wins over read clear
    // A fault arriving with the read is kept for the next read
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            parallel_detect_fault_r <= 1'b0;
        end else if (monBus.faultPulse) begin
            parallel_detect_fault_r <= 1'b1;
        end else if (expRead) begin
            parallel_detect_fault_r <= 1'b0;
        end
    end

    // latched until expansion read
    // Same priority as the fault, so no page goes unreported
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            page_received_flag_r <= 1'b0;
        end else if (pageStored) begin
            page_received_flag_r <= 1'b1;
        end else if (expRead) begin
            page_received_flag_r <= 1'b0;
        end
    end

    // partner next-page ability
    // Level follower; the partner may withdraw the ability
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            partner_next_page_capable_r <= 1'b0;
        end else begin
            partner_next_page_capable_r <= partnerNpAble;
        end
    end

    // partner autoneg capable, kept until renegotiation
    // A code word beats a renegotiation pulse in one cycle
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            partner_autoneg_capable_r <= 1'b0;
        end else if (codeWordSeen) begin
            partner_autoneg_capable_r <= 1'b1;
        end else if (renegotiate) begin
            partner_autoneg_capable_r <= 1'b0;
        end
    end

    // Next-page register; handshake bits are not stored
    // The engine owns bits 14, 12 and 11; software never lands there
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            nextPage_r <= ansnr_pkg::NP_RESET;
        end else if (wrNextPage) begin
            nextPage_r <= regWrData & ansnr_pkg::NP_SW_MASK;
        end
    end

    // Control register; only the three top bits are held
    // Lower bits belong to other blocks and read zero
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            control_r <= ansnr_pkg::CTL_RESET;
        end else if (wrControl) begin
            control_r <= regWrData & ansnr_pkg::CTL_SW_MASK;
        end
    end

    // Interrupt events
    // Capable event fires on the rising flag, not on every word
    always_comb begin
        intEvents = '0;
        intEvents[ansnr_pkg::INT_PAGE_BIT] = pageStored;
        intEvents[ansnr_pkg::INT_PDF_BIT] = monBus.faultPulse;
        intEvents[ansnr_pkg::INT_LPAN_BIT] = codeWordSeen && !partner_autoneg_capable_r;
    end

    // Sticky status; a new event beats a clear in the same cycle
    // Clear acts only on bits written as one
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            intStatus_r <= ansnr_pkg::INT_RESET;
        end else if (wrIntClear) begin
            intStatus_r <= (intStatus_r & ~regWrData[ansnr_pkg::INT_W-1:0]) | intEvents;
        end else begin
            intStatus_r <= intStatus_r | intEvents;
        end
    end

    // Interrupt enable mask
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            intEnable_r <= ansnr_pkg::INT_RESET;
        end else if (wrIntEnable) begin
            intEnable_r <= regWrData[ansnr_pkg::INT_W-1:0];
        end
    end

    // Level interrupt output
    // Registered, so the pin lags the status by one cycle
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= |(intStatus_r & intEnable_r);
        end
    end

    // forced good keeps status at one
    // Forcing wins over the pulse monitor
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            linkStatus_r <= 1'b0;
        end else begin
            linkStatus_r <= control_r[ansnr_pkg::CTL_FORCE_BIT] || linkPulseStatus;
        end
    end

    // automatic detection otherwise
    // Manual mode hands the choice to the swap bit
    assign invertNow = control_r[ansnr_pkg::CTL_MANUAL_BIT] ?
                       control_r[ansnr_pkg::CTL_SWAP_BIT] : autoPolInverted;

    // Polarity-corrected receive pair
    // Pins pass the agreement filter before the swap
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rxPolPos_r <= 1'b0;
            rxPolNeg_r <= 1'b0;
            invert_r <= 1'b0;
        end else begin
            invert_r <= invertNow;
            rxPolPos_r <= invertNow ? rxPairSync[1] : rxPairSync[0];
            rxPolNeg_r <= invertNow ? rxPairSync[0] : rxPairSync[1];
        end
    end

    // Expansion view; reserved bits zero
    always_comb begin
        expView = '0;
        expView[ansnr_pkg::EXP_PDF_BIT] = parallel_detect_fault_r;
        expView[ansnr_pkg::EXP_LPNP_BIT] = partner_next_page_capable_r;
        expView[ansnr_pkg::EXP_NPABLE_BIT] = 1'b1;
        expView[ansnr_pkg::EXP_PAGE_RECEIVED_FLAG_BIT] = page_received_flag_r;
        expView[ansnr_pkg::EXP_LPAN_BIT] = partner_autoneg_capable_r;
    end

    // Next-page view with live handshake bits
    // Handshake bits are live engine values, never stored
    always_comb begin
        npView = nextPage_r;
        npView[ansnr_pkg::NP_ACK_BIT] = npHandshakeBits[2];
        npView[ansnr_pkg::NP_SECOND_HANDSHAKE_CONFIRM_BIT] = npHandshakeBits[1];
        npView[ansnr_pkg::NP_TOGGLE_BIT] = npHandshakeBits[0];
    end

    // Read multiplexer; unmapped addresses read zero
    // Clear register is write-only and falls to the default
    always_comb begin
        rdData_nxt = '0;
        case (regAddr)
            ansnr_pkg::ADDR_EXPANSION: rdData_nxt = expView;
            ansnr_pkg::ADDR_NEXT_PAGE: rdData_nxt = npView;
            ansnr_pkg::ADDR_IDENT: rdData_nxt = IDENT_VALUE;
            ansnr_pkg::ADDR_CONTROL: rdData_nxt = control_r;
            ansnr_pkg::ADDR_INT_STATUS: rdData_nxt = {13'h0000, intStatus_r};
            ansnr_pkg::ADDR_INT_ENABLE: rdData_nxt = {13'h0000, intEnable_r};
            default: rdData_nxt = '0;
        endcase
    end

    // Read data stands one cycle after the strobe only
    // Zero between answers, so stale data never looks like a read
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdData_r <= '0;
        end else if (regRdEn) begin
            rdData_r <= rdData_nxt;
        end else begin
            rdData_r <= '0;
        end
    end

    // Read data; identifier has no write path
    assign regRdData = rdData_r;

    // Next-page word to the engine
    assign npTxWord = nextPage_r;
    assign npMoreFollows = nextPage_r[ansnr_pkg::NP_MORE_BIT];

    // Link and polarity outputs
    assign linkStatus = linkStatus_r;
    assign forceLinkGood = control_r[ansnr_pkg::CTL_FORCE_BIT];
    assign rxPolPos = rxPolPos_r;
    assign rxPolNeg = rxPolNeg_r;
    assign polarityInverted = invert_r;

    // Interrupt pin
    assign irq = irq_r;
endmodule

/* File: test/ansnr_regs_monitor.sv */
// Checker for the autonegotiation status and next-page register bank
`timescale 1ns/1ps
module ansnr_regs_monitor #(
    parameter int PDF_MIN_CYC = ansnr_pkg::PDF_MIN_CYC,
    parameter int PDF_MAX_CYC = ansnr_pkg::PDF_MAX_CYC,
    parameter logic [15:0] IDENT_VALUE = ansnr_pkg::IDENT_DEFAULT
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Register port
    input wire logic [4:0] regAddr,
    input wire logic [15:0] regWrData,
    input wire logic regWrEn,
    input wire logic regRdEn,
    input wire logic [15:0] regRdData,
    // Events
    input wire logic link10Good,
    input wire logic link100Good,
    input wire logic linkFail,
    input wire logic pageStored,
    input wire logic codeWordSeen,
    // Next page, link and polarity
    input wire logic [15:0] npTxWord,
    input wire logic npMoreFollows,
    input wire logic linkPulseStatus,
    input wire logic linkStatus,
    input wire logic forceLinkGood,
    input wire logic rxPairPos,
    input wire logic rxPairNeg,
    input wire logic rxPolPos,
    input wire logic polarityInverted
);
    localparam logic [4:0] AEXP = ansnr_pkg::ADDR_EXPANSION;
    localparam logic [4:0] ANP = ansnr_pkg::ADDR_NEXT_PAGE;
    default clocking dc @(posedge clk);
    endclocking
    default disable iff (rst);

    // Expansion read with no page-stored, link-fail or both-good event in that cycle
    sequence s_exp_rd;
        regRdEn && regAddr == AEXP && !pageStored && !linkFail && !(link10Good && link100Good);
    endsequence
    sequence s_quiet_before;
        !$past(linkFail) && !$past(link10Good && link100Good);
    endsequence
    sequence s_np_wr;
        regWrEn && regAddr == ANP;
    endsequence

    // Read-only fields of the expansion and identifier registers
    property p_ident;
        regRdEn && regAddr == ansnr_pkg::ADDR_IDENT |=> regRdData == IDENT_VALUE;
    endproperty
    property p_np_able;
        regRdEn && regAddr == AEXP |=> regRdData[2] == 1'b1;
    endproperty
    property p_reserved;
        regRdEn && regAddr == AEXP |=> regRdData[15:5] == 11'h000;
    endproperty
    // A read clears the latched flags for the next read; a code word sets the capable flag
    property p_page_received_flag_clear;
        s_exp_rd ##1 s_exp_rd |=> regRdData[1] == 1'b0;
    endproperty
    property p_pdf_clear;
        (s_exp_rd ##0 s_quiet_before) ##1 s_exp_rd |=> regRdData[4] == 1'b0;
    endproperty
    property p_lpan_set;
        codeWordSeen ##1 (regRdEn && regAddr == AEXP) |=> regRdData[0] == 1'b1;
    endproperty
    // Next-page writes keep the handshake bits clear
    property p_np_write;
        s_np_wr |=> npTxWord == ($past(regWrData) & ansnr_pkg::NP_SW_MASK);
    endproperty
    property p_more_follows;
        s_np_wr |=> npMoreFollows == $past(regWrData[15]);
    endproperty
    // Link status against forcing and pulses
    property p_force_good;
        forceLinkGood |=> linkStatus;
    endproperty
    property p_pulse_loss;
        !forceLinkGood && !linkPulseStatus |=> !linkStatus;
    endproperty
    // Settled pair follows pins and inversion
    property p_pol;
        ($stable({rxPairPos, rxPairNeg, polarityInverted}) && rxPairPos != rxPairNeg) [*8]
            |-> rxPolPos == (rxPairPos ^ polarityInverted);
    endproperty

    a_ident: assert property (p_ident) else $error("identifier read wrong");
    a_np_able: assert property (p_np_able) else $error("next-page able bit low");
    a_reserved: assert property (p_reserved) else $error("reserved bits set");
    a_page_received_flag_clear: assert property (p_page_received_flag_clear) else $error("page flag kept");
    a_pdf_clear: assert property (p_pdf_clear) else $error("fault flag kept");
    a_lpan_set: assert property (p_lpan_set) else $error("partner capable unset");
    a_np_write: assert property (p_np_write) else $error("next-page word wrong");
    a_more_follows: assert property (p_more_follows) else $error("more pages wrong");
    a_force_good: assert property (p_force_good) else $error("forced link dropped");
    a_pulse_loss: assert property (p_pulse_loss) else $error("link kept");
    a_pol: assert property (p_pol) else $error("pair polarity wrong");
endmodule

bind ansnr_regs ansnr_regs_monitor #(
    .PDF_MIN_CYC(PDF_MIN_CYC), .PDF_MAX_CYC(PDF_MAX_CYC), .IDENT_VALUE(IDENT_VALUE)
) mon_u (
    .clk, .rst, .regAddr, .regWrData, .regWrEn, .regRdEn, .regRdData, .link10Good,
    .link100Good, .linkFail, .pageStored, .codeWordSeen, .npTxWord, .npMoreFollows,
    .linkPulseStatus, .linkStatus, .forceLinkGood, .rxPairPos, .rxPairNeg, .rxPolPos,
    .polarityInverted
);

/* File: test/ansnr_regs_test.sv */
// Self-checking bench for the autonegotiation register bank
`timescale 1ns/1ps
module ansnr_regs_test;
    // Identifier value; arbitrary
    localparam logic [15:0] IDV = 16'h3C3C;
    localparam logic [4:0] AEXP = ansnr_pkg::ADDR_EXPANSION;
    localparam logic [4:0] ANP = ansnr_pkg::ADDR_NEXT_PAGE;
    localparam logic [4:0] ACTL = ansnr_pkg::ADDR_CONTROL;
    localparam logic [4:0] AST = ansnr_pkg::ADDR_INT_STATUS;
    localparam logic [4:0] ACLR = ansnr_pkg::ADDR_INT_CLEAR;
    localparam logic [4:0] AEN = ansnr_pkg::ADDR_INT_ENABLE;
    logic clk = 1'b0, rst = 1'b1;
    logic [4:0] regAddr = 5'h00;
    logic [15:0] regWrData = 16'h0000;
    logic regWrEn = 1'b0, regRdEn = 1'b0, autonegActive = 1'b0, linkValidDet = 1'b0;
    logic linkFail = 1'b0, link10Good = 1'b0, link100Good = 1'b0, pageStored = 1'b0;
    logic codeWordSeen = 1'b0, partnerNpAble = 1'b0, renegotiate = 1'b0;
    logic [2:0] npHandshakeBits = 3'h0;
    logic linkPulseStatus = 1'b0, rxPairPos = 1'b1, rxPairNeg = 1'b0, autoPolInverted = 1'b0;
    logic [15:0] regRdData, npTxWord;
    logic npMoreFollows, linkStatus, forceLinkGood, rxPolPos, rxPolNeg, polarityInverted, irq;
    int nFail = 0, nChecks = 0;

    ansnr_regs #(.PDF_MIN_CYC(5), .PDF_MAX_CYC(10), .IDENT_VALUE(IDV)) dut_u (
        .clk, .rst, .regAddr, .regWrData, .regWrEn, .regRdEn, .regRdData, .autonegActive,
        .linkValidDet, .linkFail, .link10Good, .link100Good, .pageStored, .codeWordSeen,
        .partnerNpAble, .renegotiate, .npHandshakeBits, .npTxWord, .npMoreFollows,
        .linkPulseStatus, .linkStatus, .forceLinkGood, .rxPairPos, .rxPairNeg,
        .autoPolInverted, .rxPolPos, .rxPolNeg, .polarityInverted, .irq
    );

    // Clock at 125 MHz
    initial begin
        forever #4 clk = ~clk;
    end

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        nChecks++;
        if (got !== exp) begin
            nFail++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask
    task automatic chkBit(input string what, input logic exp, input logic got);
        nChecks++;
        if (got !== exp) begin
            nFail++;
            $display("unexpected %s: expected %b, seen %b", what, exp, got);
        end
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // One-cycle register write and read
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        regAddr <= a;
        regWrData <= d;
        regWrEn <= 1'b1;
        @(posedge clk);
        regWrEn <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [4:0] a, input logic [15:0] exp, input string what);
        regAddr <= a;
        regRdEn <= 1'b1;
        @(posedge clk);
        regRdEn <= 1'b0;
        #1 chk(what, exp, regRdData);
    endtask
    task automatic wrapUp;
        if (nFail == 0 && nChecks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic t_reset;
        chk("npTxWord", 16'h2001, npTxWord);
        rd(AEXP, 16'h0004, "expansion");
        rd(ANP, 16'h2001, "next page");
        rd(ACTL, 16'h0000, "control");
        rd(5'h03, 16'h0000, "unmapped");
        wr(ansnr_pkg::ADDR_IDENT, 16'hFFFF);
        rd(ansnr_pkg::ADDR_IDENT, IDV, "identifier");
        chk("npTxWord", 16'h2001, npTxWord);
    endtask
    task automatic t_np;
        wr(ANP, 16'hFFFF);
        chk("npTxWord", 16'hA7FF, npTxWord);
        chkBit("npMoreFollows", 1'b1, npMoreFollows);
        npHandshakeBits <= 3'b101;
        rd(ANP, 16'hEFFF, "next page");
        wr(ANP, 16'h0005);
        chk("npTxWord", 16'h0005, npTxWord);
        chkBit("npMoreFollows", 1'b0, npMoreFollows);
        npHandshakeBits <= 3'b000;
    endtask
    task automatic t_flags;
        pageStored <= 1'b1;
        @(posedge clk);
        pageStored <= 1'b0;
        #1 rd(AEXP, 16'h0006, "page flag");
        rd(AEXP, 16'h0004, "page flag");
        codeWordSeen <= 1'b1;
        @(posedge clk);
        codeWordSeen <= 1'b0;
        #1 rd(AEXP, 16'h0005, "partner capable");
        partnerNpAble <= 1'b1;
        idle(2);
        rd(AEXP, 16'h000D, "partner next page");
        renegotiate <= 1'b1;
        @(posedge clk);
        renegotiate <= 1'b0;
        partnerNpAble <= 1'b0;
        idle(2);
        rd(AEXP, 16'h0004, "renegotiated");
    endtask
    task automatic t_pdf;
        int k[4] = '{4, 5, 10, 11};
        autonegActive <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            linkValidDet <= 1'b1;
            @(posedge clk);
            linkValidDet <= 1'b0;
            repeat (k[i]) @(posedge clk);
            linkFail <= 1'b1;
            @(posedge clk);
            linkFail <= 1'b0;
            idle(3);
            rd(AEXP, (i == 1 || i == 2) ? 16'h0014 : 16'h0004, "window fault");
        end
        for (int j = 1; j >= 0; j--) begin
            autonegActive <= j[0];
            link10Good <= 1'b1;
            link100Good <= 1'b1;
            @(posedge clk);
            link10Good <= 1'b0;
            link100Good <= 1'b0;
            idle(3);
            rd(AEXP, j ? 16'h0014 : 16'h0004, "both good fault");
            rd(AEXP, 16'h0004, "fault cleared");
        end
    endtask
    task automatic t_irq;
        rd(AST, 16'h0007, "int status");
        chkBit("irq disabled", 1'b0, irq);
        wr(ACLR, 16'h0007);
        wr(AEN, 16'h0007);
        rd(AEN, 16'h0007, "int enable");
        rd(AST, 16'h0000, "int status");
        pageStored <= 1'b1;
        @(posedge clk);
        pageStored <= 1'b0;
        idle(2);
        chkBit("irq", 1'b1, irq);
        rd(AST, 16'h0001, "int status");
        wr(AEN, 16'h0006);
        idle(2);
        chkBit("irq masked", 1'b0, irq);
        wr(ACLR, 16'h0001);
        wr(AEN, 16'h0007);
        idle(2);
        chkBit("irq cleared", 1'b0, irq);
        rd(AST, 16'h0000, "int status");
        rd(ACLR, 16'h0000, "int clear");
    endtask
    task automatic t_link;
        idle(2);
        chkBit("linkStatus", 1'b0, linkStatus);
        linkPulseStatus <= 1'b1;
        idle(2);
        chkBit("linkStatus", 1'b1, linkStatus);
        linkPulseStatus <= 1'b0;
        wr(ACTL, 16'h9FFF);
        idle(2);
        chkBit("forceLinkGood", 1'b1, forceLinkGood);
        chkBit("linkStatus", 1'b1, linkStatus);
        rd(ACTL, 16'h8000, "control");
        wr(ACTL, 16'h0000);
        idle(2);
        chkBit("linkStatus", 1'b0, linkStatus);
    endtask
    task automatic t_pol;
        logic [15:0] ctl[4] = '{16'h0000, 16'h0000, 16'h2000, 16'h6000};
        for (int m = 0; m < 4; m++) begin
            wr(ACTL, ctl[m]);
            autoPolInverted <= m[0] ^ m[1];
            rxPairPos <= ~m[1];
            rxPairNeg <= m[1];
            idle(8);
            chkBit("polarityInverted", m[0], polarityInverted);
            chkBit("rxPolPos", ~(m[0] ^ m[1]), rxPolPos);
            chkBit("rxPolNeg", m[0] ^ m[1], rxPolNeg);
        end
    endtask

    // Watchdog against a hang
    initial begin
        repeat (20000) @(posedge clk);
        nFail++;
        wrapUp();
    end
    // Main sequence
    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        #1;
        t_reset();
        t_np();
        t_flags();
        t_pdf();
        t_irq();
        t_link();
        t_pol();
        wrapUp();
    end
endmodule
